// ==== xor_div_pkg.sv ====
package xor_div_pkg;

    localparam logic [7:0] OP_PREFIX_Y   = 8'h18;
    localparam logic [7:0] OP_XA_IMM     = 8'h88;
    localparam logic [7:0] OP_XA_DIR     = 8'h98;
    localparam logic [7:0] OP_XA_EXT     = 8'hB8;
    localparam logic [7:0] OP_XA_IDX     = 8'hA8;
    localparam logic [7:0] OP_XB_IMM     = 8'hC8;
    localparam logic [7:0] OP_XB_DIR     = 8'hD8;
    localparam logic [7:0] OP_XB_EXT     = 8'hF8;
    localparam logic [7:0] OP_XB_IDX     = 8'hE8;
    localparam logic [7:0] OP_INT_DIV    = 8'h02;
    localparam logic [7:0] OP_FRAC_DIV   = 8'h03;

    localparam logic [15:0] IDLE_ADDR    = 16'hFFFF;
    localparam logic [15:0] QUOT_SAT     = 16'hFFFF;
    localparam logic [15:0] ZERO_WORD    = 16'h0000;
    localparam logic [7:0]  DIRECT_PAGE  = 8'h00;

    // total cycles of a divide, counting the opcode fetch as cycle 1
    localparam int unsigned DIV_CYCLES   = 41;
    localparam logic [5:0]  DIV_LAST     = 6'(DIV_CYCLES);
    localparam logic [5:0]  DIV_STEP0    = 6'h03;
    localparam logic [5:0]  DIV_BITS     = 6'h10;

    typedef enum logic [3:0] {
        ST_FETCH  = 4'b0000,
        ST_OPND1  = 4'b0001,
        ST_OPND2  = 4'b0011,
        ST_DUMMY  = 4'b0010,
        ST_READ   = 4'b0110,
        ST_DIV    = 4'b0111,
        ST_PREFIX = 4'b0101
    } phase_e;

    typedef enum logic [2:0] {
        AM_IMM = 3'd0,
        AM_DIR = 3'd1,
        AM_EXT = 3'd2,
        AM_IDX = 3'd3,
        AM_IDY = 3'd4,
        AM_INH = 3'd5
    } amode_e;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } flags_s;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
    } mbus_s;

endpackage

// ==== div_step.sv ====
`timescale 1ns/10ps
// one restoring-division step: shift a numerator bit in, try subtract
module div_step
    import xor_div_pkg::*;
(
    input  wire logic [16:0] rem_in,
    input  wire logic        bit_in,
    input  wire logic [15:0] den,
    output logic      [16:0] rem_out,
    output logic             q_bit
);
    logic [17:0] trial;
    logic [17:0] diff;

    always_comb
    begin
        trial   = {rem_in, bit_in};
        diff    = trial - {2'b00, den};
        q_bit   = ~diff[17];
        rem_out = q_bit ? diff[16:0] : trial[16:0];
    end

endmodule

// ==== xor_div_exec.sv ====
`timescale 1ns/10ps
module xor_div_exec
    import xor_div_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        start,
    input  wire logic [15:0] pc,
    input  wire logic [7:0]  rd_data,
    input  wire logic [7:0]  acc_a,
    input  wire logic [7:0]  acc_b,
    input  wire logic [15:0] index_register_x,
    input  wire logic [15:0] index_register_y,
    input  wire flags_s      flags_in,
    output mbus_s            bus,
    output logic             busy,
    output logic             done,
    output logic             wr_acc_a,
    output logic             wr_acc_b,
    output logic [7:0]       acc_result,
    output logic             wr_div,
    output logic [15:0]      quot_out,
    output logic [15:0]      rem_out,
    output flags_s           flags_out
);

    typedef struct packed {
        phase_e      ph;
        amode_e      am;
        logic        sel_b;
        logic        frac;
        logic        bad;
        logic [15:0] pc;
        logic [15:0] ea;
        logic [5:0]  cyc;
        logic [15:0] num;
        logic [16:0] rem;
        logic [15:0] quo;
        logic [15:0] den;
        logic        ovf;
        logic        dzero;
        mbus_s       bus;
        logic        done;
        logic        wr_a;
        logic        wr_b;
        logic        wr_div;
        logic [7:0]  accr;
        logic [15:0] qout;
        logic [15:0] rout;
        flags_s      fl;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic [16:0] step_rem;
    logic        step_q;
    logic [7:0]  xor_res;
    logic [15:0] q_final;

    // numerator bits enter msb first; fraction mode feeds zeros after them
    div_step u_step (
        .rem_in  (s_q.rem),
        .bit_in  (s_q.num[15]),
        .den     (s_q.den),
        .rem_out (step_rem),
        .q_bit   (step_q)
    );

    always_comb
    begin
        xor_res = (s_q.sel_b ? acc_b : acc_a) ^ rd_data;
        q_final = s_q.bad ? QUOT_SAT : s_q.quo;
        s_d        = s_q;
        s_d.done   = 1'b0;
        s_d.wr_a   = 1'b0;
        s_d.wr_b   = 1'b0;
        s_d.wr_div = 1'b0;
        s_d.bus.rd = 1'b1;
        s_d.pc     = s_q.pc + 16'h0001;
        s_d.bus.addr = s_d.pc;
        unique case (s_q.ph)
            ST_FETCH:
            begin
                s_d.bus.rd = 1'b0;
                if (start)
                begin
                    // pc tracks the address on the bus; a stale Y prefix
                    // from the last instruction must not leak into this one
                    s_d.pc       = pc;
                    s_d.am       = AM_IMM;
                    s_d.bus.addr = pc;
                    s_d.bus.rd   = 1'b1;
                    s_d.ph       = ST_PREFIX;
                end
            end
            ST_PREFIX:
            begin
                // opcode byte is on rd_data now; next read is pc+1
                s_d.ph = ST_OPND1;
                s_d.am = AM_IMM;
                unique case (rd_data)
                    OP_XA_IMM: begin s_d.sel_b = 1'b0; s_d.am = AM_IMM; end
                    OP_XA_DIR: begin s_d.sel_b = 1'b0; s_d.am = AM_DIR; end
                    OP_XA_EXT: begin s_d.sel_b = 1'b0; s_d.am = AM_EXT; end
                    OP_XB_IMM: begin s_d.sel_b = 1'b1; s_d.am = AM_IMM; end
                    OP_XB_DIR: begin s_d.sel_b = 1'b1; s_d.am = AM_DIR; end
                    OP_XB_EXT: begin s_d.sel_b = 1'b1; s_d.am = AM_EXT; end
                    OP_XA_IDX:
                    begin
                        s_d.sel_b = 1'b0;
                        s_d.am = (s_q.am == AM_IDY) ? AM_IDY : AM_IDX;
                    end
                    OP_XB_IDX:
                    begin
                        s_d.sel_b = 1'b1;
                        s_d.am = (s_q.am == AM_IDY) ? AM_IDY : AM_IDX;
                    end
                    OP_PREFIX_Y:
                    begin
                        s_d.am = AM_IDY;
                        s_d.ph = ST_PREFIX;
                    end
                    OP_INT_DIV, OP_FRAC_DIV:
                    begin
                        s_d.am    = AM_INH;
                        s_d.frac  = (rd_data == OP_FRAC_DIV);
                        s_d.num   = {acc_a, acc_b};
                        s_d.den   = index_register_x;
                        s_d.rem   = 17'h0_0000;
                        s_d.quo   = ZERO_WORD;
                        s_d.dzero = (index_register_x == ZERO_WORD);
                        s_d.ovf   = index_register_x <= {acc_a, acc_b};
                        s_d.bad   = (rd_data == OP_FRAC_DIV)
                                  ? (index_register_x <= {acc_a, acc_b})
                                  : (index_register_x == ZERO_WORD);
                        s_d.cyc   = DIV_STEP0;
                        s_d.ph    = ST_OPND1;
                    end
                    default:
                    begin
                        // not ours: drop out without reading further
                        s_d.bus.rd = 1'b0;
                        s_d.ph     = ST_FETCH;
                    end
                endcase
                if (s_q.am == AM_IDY && rd_data == OP_PREFIX_Y)
                begin
                    s_d.bus.rd = 1'b0;
                    s_d.ph     = ST_FETCH;
                end
            end
            ST_OPND1:
            begin
                s_d.ea = {DIRECT_PAGE, rd_data};
                unique case (s_q.am)
                    AM_IMM:
                    begin
                        s_d.ph = ST_FETCH;
                        s_d.bus.rd = 1'b0;
                    end
                    AM_DIR:
                    begin
                        s_d.bus.addr = {DIRECT_PAGE, rd_data};
                        s_d.pc = s_q.pc;
                        s_d.ph = ST_READ;
                    end
                    AM_EXT:
                    begin
                        s_d.ea[15:8] = rd_data;
                        s_d.ph = ST_OPND2;
                    end
                    AM_IDX, AM_IDY:
                    begin
                        s_d.ea = ((s_q.am == AM_IDY) ? index_register_y
                                 : index_register_x) + {8'h00, rd_data};
                        s_d.bus.addr = IDLE_ADDR;
                        s_d.pc = s_q.pc;
                        s_d.ph = ST_DUMMY;
                    end
                    default:
                    begin
                        s_d.bus.addr = IDLE_ADDR;
                        s_d.pc = s_q.pc;
                        s_d.ph = ST_DIV;
                    end
                endcase
            end
            ST_OPND2:
            begin
                s_d.bus.addr = {s_q.ea[15:8], rd_data};
                s_d.pc = s_q.pc;
                s_d.ph = ST_READ;
            end
            ST_DUMMY:
            begin
                s_d.bus.addr = s_q.ea;
                s_d.pc = s_q.pc;
                s_d.ph = ST_READ;
            end
            ST_READ:
            begin
                s_d.pc = s_q.pc;
                s_d.bus.rd = 1'b0;
                s_d.ph = ST_FETCH;
            end
            ST_DIV:
            begin
                s_d.pc = s_q.pc;
                s_d.bus.addr = IDLE_ADDR;
                s_d.cyc = s_q.cyc + 6'h01;
                // 32 steps: 16 numerator bits then 16 zero bits
                // integer mode keeps only the first 16 steps' quotient
                if (s_q.cyc < DIV_STEP0 + DIV_BITS + DIV_BITS)
                begin
                    if (s_q.frac || s_q.cyc < DIV_STEP0 + DIV_BITS)
                    begin
                        s_d.rem = step_rem;
                        s_d.quo = {s_q.quo[14:0], step_q};
                        s_d.num = {s_q.num[14:0], 1'b0};
                    end
                end
                if (s_q.cyc == DIV_LAST)
                begin
                    s_d.bus.rd = 1'b0;
                    s_d.done   = 1'b1;
                    s_d.wr_div = 1'b1;
                    s_d.qout   = q_final;
                    s_d.rout   = s_q.rem[15:0];
                    s_d.fl.n   = flags_in.n;
                    s_d.fl.z   = (q_final == ZERO_WORD);
                    s_d.fl.v   = s_q.frac & s_q.ovf;
                    s_d.fl.c   = s_q.dzero;
                    s_d.ph     = ST_FETCH;
                end
            end
            default:
            begin
                s_d.ph = ST_FETCH;
                s_d.bus.rd = 1'b0;
            end
        endcase
        // immediate data stands on rd_data in the operand cycle itself
        if (s_q.ph == ST_READ || (s_q.ph == ST_OPND1 && s_q.am == AM_IMM))
        begin
            s_d.done = 1'b1;
            s_d.wr_a = ~s_q.sel_b;
            s_d.wr_b = s_q.sel_b;
            s_d.accr = xor_res;
            s_d.fl.n = xor_res[7];
            s_d.fl.z = (xor_res == 8'h00);
            s_d.fl.v = 1'b0;
            s_d.fl.c = flags_in.c;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
            s_q.ph <= ST_FETCH;
            s_q.am <= AM_IMM;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign bus        = s_q.bus;
    assign busy       = (s_q.ph != ST_FETCH);
    assign done       = s_q.done;
    assign wr_acc_a   = s_q.wr_a;
    assign wr_acc_b   = s_q.wr_b;
    assign acc_result = s_q.accr;
    assign wr_div     = s_q.wr_div;
    assign quot_out   = s_q.qout;
    assign rem_out    = s_q.rout;
    assign flags_out  = s_q.fl;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sat_quot_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_div && flags_out.v |-> quot_out == QUOT_SAT)
        else $error("saturated quotient expected");
    zero_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_div |-> flags_out.z == (quot_out == ZERO_WORD))
        else $error("zero flag disagrees with quotient");
    carry_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_div && flags_out.c |-> quot_out == QUOT_SAT)
        else $error("zero divide must saturate");
    div_length_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_q.ph == ST_DIV && s_q.cyc == DIV_STEP0 |-> ##39 wr_div)
        else $error("divide length wrong");
    idle_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_q.ph == ST_DIV |-> bus.addr == IDLE_ADDR && bus.rd)
        else $error("divide must idle on FFFF");
    xor_flags_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (wr_acc_a || wr_acc_b) |-> !flags_out.v
        && flags_out.n == acc_result[7])
        else $error("xor flags wrong");
    idx_dummy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_q.ph == ST_DUMMY |-> bus.addr == IDLE_ADDR
        ##1 bus.addr == $past(s_q.ea))
        else $error("indexed dummy read missing");
    int_ovf_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_div && !$past(s_q.frac) |-> !flags_out.v)
        else $error("integer divide must clear overflow");

endmodule

// ==== xor_and_divide_execution_tb_top.sv ====
`timescale 1ns/10ps
module xor_and_divide_execution_tb_top
    import xor_div_pkg::*;
();

    typedef struct packed {
        amode_e      m;
        logic [7:0]  op, b1, b2, a, b;
        logic [15:0] x, oa;
        logic [7:0]  ov;
        logic [15:0] q, r;
        flags_s      fi, fo;
    } row_s;

    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        start = 1'b0;
    logic [15:0] pc = '0;
    logic [7:0]  rd_data = '0;
    logic [7:0]  acc_a = '0;
    logic [7:0]  acc_b = '0;
    logic [15:0] index_register_x = '0;
    logic [15:0] index_register_y = '0;
    flags_s      flags_in = '0;
    mbus_s       bus;
    logic        busy, done, wr_acc_a, wr_acc_b, wr_div;
    logic [7:0]  acc_result;
    logic [15:0] quot_out, rem_out;
    flags_s      flags_out;
    logic [7:0]  mem [0:65535];
    int          error_cnt = 0;
    int          checks = 0;
    row_s        rows [18] = '{
        '{AM_IMM,8'h88,8'h5A,'0,8'hF0,'0,'0,16'h2001,8'h5A,16'h00AA,'0,
          4'h7,4'h9},
        '{AM_DIR,8'h98,8'h40,'0,8'h3C,'0,'0,16'h0040,8'h3C,'0,'0,4'hA,4'h4},
        '{AM_EXT,8'hB8,8'h12,8'h34,'0,'0,'0,16'h1234,8'hFF,16'h00FF,'0,
          4'h0,4'h8},
        '{AM_IDX,8'hA8,8'hFF,'0,8'hF0,'0,16'h30F0,16'h31EF,8'h0F,16'h00FF,'0,
          4'h1,4'h9},
        '{AM_IDY,8'hA8,8'h10,'0,8'h01,'0,16'hFFF8,16'h0008,8'h81,16'h0080,'0,
          4'h6,4'h8},
        '{AM_IMM,8'hC8,8'hFF,'0,'0,8'hFF,'0,16'h2001,8'hFF,'0,'0,4'h0,4'h4},
        '{AM_DIR,8'hD8,8'hFF,'0,'0,8'h21,'0,16'h00FF,8'h12,16'h0033,'0,
          4'h3,4'h1},
        '{AM_EXT,8'hF8,8'h0F,8'h00,'0,'0,'0,16'h0F00,8'h80,16'h0080,'0,
          4'h0,4'h8},
        '{AM_IDX,8'hE8,8'h00,'0,'0,8'hAA,16'h0500,16'h0500,8'h55,16'h00FF,'0,
          4'h5,4'h9},
        '{AM_IDY,8'hE8,8'h7F,'0,'0,8'hF0,16'h0100,16'h017F,8'h0F,16'h00FF,'0,
          4'h0,4'h8},
        '{AM_INH,8'h02,'0,'0,8'h12,8'h34,16'h0010,'0,'0,16'h0123,16'h0004,
          4'hF,4'h8},
        '{AM_INH,8'h02,'0,'0,'0,8'h05,'0,'0,'0,16'hFFFF,'0,4'h0,4'h1},
        '{AM_INH,8'h02,'0,'0,'0,8'h03,16'h0007,'0,'0,'0,16'h0003,4'hA,4'hC},
        '{AM_INH,8'h03,'0,'0,'0,8'h01,16'h0002,'0,'0,16'h8000,'0,4'h7,4'h0},
        '{AM_INH,8'h03,'0,'0,'0,8'h02,16'h0002,'0,'0,16'hFFFF,'0,4'h0,4'h2},
        '{AM_INH,8'h03,'0,'0,'0,'0,'0,'0,'0,16'hFFFF,'0,4'h0,4'h3},
        '{AM_INH,8'h03,'0,'0,'0,8'h01,16'hFFFF,'0,'0,16'h0001,16'h0001,
          4'h8,4'h8},
        '{AM_INH,8'h03,'0,'0,'0,'0,16'h0003,'0,'0,'0,'0,4'h0,4'h4}
    };

    xor_div_exec DUT (
        .clk_sys          (clk_sys),
        .sys_rst          (sys_rst),
        .start            (start),
        .pc               (pc),
        .rd_data          (rd_data),
        .acc_a            (acc_a),
        .acc_b            (acc_b),
        .index_register_x (index_register_x),
        .index_register_y (index_register_y),
        .flags_in         (flags_in),
        .bus              (bus),
        .busy             (busy),
        .done             (done),
        .wr_acc_a         (wr_acc_a),
        .wr_acc_b         (wr_acc_b),
        .acc_result       (acc_result),
        .wr_div           (wr_div),
        .quot_out         (quot_out),
        .rem_out          (rem_out),
        .flags_out        (flags_out)
    );

    always #10 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    // memory answers within the cycle its address stands; the design takes
    // the byte at the closing edge. no read means no stale data
    always @(posedge clk_sys)
    begin
        #1;
        rd_data = bus.rd ? mem[bus.addr] : ~rd_data;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] got,
                         input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check_idle();
        check("bus", bus, '0);
        check("busy", busy, '0);
        check("done", done, '0);
        check("flags", flags_out, '0);
    endtask

    // hold keeps start up so the next fetch follows straight after done
    task automatic run(input row_s w, input bit hold);
        logic [15:0] e[$];
        logic [15:0] got[$];
        int          n;
        logic        sel_a;
        case (w.m)
            AM_IMM: e = {16'h2000, 16'h2001};
            AM_DIR: e = {16'h2000, 16'h2001, w.oa};
            AM_EXT: e = {16'h2000, 16'h2001, 16'h2002, w.oa};
            AM_IDX: e = {16'h2000, 16'h2001, IDLE_ADDR, w.oa};
            AM_IDY: e = {16'h2000, 16'h2001, 16'h2002, IDLE_ADDR, w.oa};
            default:
            begin
                e = {16'h2000, 16'h2001};
                repeat (39) e.push_back(IDLE_ADDR);
            end
        endcase
        mem[16'h2000] = (w.m == AM_IDY) ? OP_PREFIX_Y : w.op;
        mem[16'h2001] = (w.m == AM_IDY) ? w.op : w.b1;
        mem[16'h2002] = (w.m == AM_IDY) ? w.b1 : w.b2;
        if (w.m != AM_INH)
            mem[w.oa] = w.ov;
        @(posedge clk_sys);
        #1;
        start = 1'b1;
        pc = 16'h2000;
        acc_a = w.a;
        acc_b = w.b;
        index_register_x = (w.m == AM_IDY) ? ~w.x : w.x;
        index_register_y = (w.m == AM_IDY) ? w.x : ~w.x;
        flags_in = w.fi;
        @(posedge clk_sys);
        #1;
        if (hold)
            pc = 16'h3000;
        else
            start = 1'b0;
        n = 0;
        forever
        begin
            @(negedge clk_sys);
            n++;
            if (done === 1'b1)
                break;
            if (bus.rd === 1'b1)
                got.push_back(bus.addr);
            if (n > 60)
            begin
                error_cnt++;
                finish_test();
            end
        end
        check("cycles", n, e.size() + 1);
        check("reads", got.size(), e.size());
        foreach (e[i])
            check("addr", got[i], e[i]);
        sel_a = w.op < 8'hC0;
        check("wr_div", wr_div, w.m == AM_INH);
        check("flags", flags_out, w.fo);
        if (w.m == AM_INH)
        begin
            check("quot", quot_out, w.q);
            if (w.q !== QUOT_SAT)
                check("rem", rem_out, w.r);
        end
        else
        begin
            check("wr_a", wr_acc_a, sel_a);
            check("wr_b", wr_acc_b, !sel_a);
            check("result", acc_result, w.q[7:0]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        int seen;
        foreach (mem[i])
            mem[i] = 8'(i) ^ 8'hA5;
        mem[16'h3000] = 8'h01;
        repeat (16) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        check_idle();
        foreach (rows[i])
            run(rows[i], 1'b0);
        // held start: ignored while busy, fetched again in the cycle after done
        run(rows[10], 1'b1);
        @(negedge clk_sys);
        check("next_fetch", bus.addr, 16'h3000);
        @(posedge clk_sys);
        #1;
        start = 1'b0;
        seen = 0;
        repeat (12)
        begin
            @(negedge clk_sys);
            if (done === 1'b1)
                seen++;
        end
        check("unknown_done", seen, 0);
        check("unknown_rd", bus.rd, 1'b0);
        @(posedge clk_sys);
        #1;
        sys_rst = 1'b1;
        @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        check_idle();
        // reset in the middle of a divide must abort it cleanly
        start = 1'b1;
        pc = 16'h2000;
        @(posedge clk_sys);
        #1;
        start = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        sys_rst = 1'b1;
        @(negedge clk_sys);
        check_idle();
        check("rst_wr_div", wr_div, 1'b0);
        @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        run(rows[13], 1'b0);
        finish_test();
    end

endmodule
